//--- logic/asc_serial_port.sv
/*
 * serial port of the converter: conversion / sleep / data state
 * machine on the system clock, frame logic on the serial clock.
 * assumes the analog core delivers a result and an overrange pair;
 * the conversion is modelled by a cycle counter.
 */
`timescale 1ns/1ps
`include "asc_consts.svh"

module asc_serial_port
  import asc_pkg::*;
#(
  parameter int CONV_CYCLES = `ASC_CONV_US * `ASC_CLK_MHZ
) (
  input  wire logic                    i_clk,       // system clock
  input  wire logic                    i_rst,       // sync reset, high
  input  wire logic                    i_sclk,      // serial clock
  input  wire logic                    i_cs_n,      // chip select, low
  input  wire logic                    i_sdi,       // serial data in
  input  wire logic [`ASC_RES_BITS-1:0] i_result,   // signed core result
  input  wire logic                    i_over,      // input above +fs
  input  wire logic                    i_under,     // input below -fs
  output logic                         o_sdo,       // serial out level
  output logic                         o_sdo_oe_n,  // low when driving
  output logic                         o_converting,// conversion running
  output logic                         o_sleeping,  // low-power sleep
  output asc_chan_t                    o_chan,      // active channel
  output asc_cfg_t                     o_cfg        // active config
);

  // ****************************************************************
  // checks
  // ****************************************************************
  // the timer needs at least two cycles to tell start from end
  if (CONV_CYCLES < 2) begin : g_conv_chk
    $error("asc_serial_port: conversion too short");
  end

  // ****************************************************************
  // state machine types
  // ****************************************************************
  typedef enum logic [2:0] {
    ASC_CONV  = 3'b001,   // converting
    ASC_SLEEP = 3'b010,   // done, waiting
    ASC_DATA  = 3'b100    // word being read
  } asc_state_t;

  asc_state_t            state_r;        // current state
  asc_state_t            state_nxt;      // next state
  logic [31:0]           conv_cnt_r;     // conversion timer
  logic [`ASC_OUT_BITS-1:0] word_r;      // latched output word
  asc_result_t           res_r;          // held result
  asc_chan_t             chan_nxt;       // next channel
  asc_cfg_t              cfg_nxt;        // next config

  // ****************************************************************
  // chip select synchroniser
  // ****************************************************************
  logic                  cs_m_r;         // first stage
  logic                  cs_s_r;         // second stage
  logic                  cs_d_r;         // previous synced

  always_ff @(posedge i_clk) begin
    cs_m_r <= i_cs_n;
    cs_s_r <= cs_m_r;
    cs_d_r <= cs_s_r;
  end

  wire cs_fall = cs_d_r & ~cs_s_r;     // select asserted
  wire cs_rise = ~cs_d_r & cs_s_r;     // select released

  // ****************************************************************
  // word-done toggle and rise count crossing
  // ****************************************************************
  logic                  done_tgl;       // serial-clock toggle
  logic [2:0]            done_sync_r;    // two stages + history
  logic [`ASC_CNT_W-1:0] rise_cnt;       // serial-clock count
  logic [`ASC_IN_BITS-1:0] rx_word;      // serial-clock word
  logic                  tx_bit;         // outgoing bit
  logic                  arm_r;          // frame arm toggle

  // cleared with the serial half so no false word-done follows reset
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      done_sync_r <= '0;
    end else begin
      done_sync_r <= {done_sync_r[1:0], done_tgl};
    end
  end

  wire word_done = done_sync_r[2] ^ done_sync_r[1];   // full word read

  // ****************************************************************
  // serial-clock half
  // ****************************************************************
  asc_sclk_side u_sclk (
    .i_sclk      (i_sclk),
    .i_cs_n      (i_cs_n),
    .i_clr       (i_rst),
    .i_frame_arm (arm_r),
    .i_word      (word_r),
    .i_sdi       (i_sdi),
    .o_tx_bit    (tx_bit),
    .o_rise_cnt  (rise_cnt),
    .o_done_tgl  (done_tgl),
    .o_rx_word   (rx_word)
  );

  // ****************************************************************
  // result formatting with range flags
  // ****************************************************************
  wire [`ASC_RES_BITS-1:0] clamp_val =
      i_over  ? {1'b1, {(`ASC_RES_BITS-1){1'b0}}} :
      i_under ? {1'b0, {(`ASC_RES_BITS-1){1'b1}}} :
                i_result;
  wire pol = i_over | (~i_under & ~i_result[`ASC_RES_BITS-1]);

  // output word: status, filler, polarity, result, zeros
  wire [`ASC_OUT_BITS-1:0] word_fmt =
      {1'b0, 1'b0, res_r.polarity_flag, res_r.value, 4'h0};

  // ****************************************************************
  // input word decode
  // ****************************************************************
  wire [2:0] pre = rx_word[`ASC_PRE_HI:`ASC_PRE_LO];
  wire load_ch  = (pre == `ASC_PRE_LOAD);
  wire load_cfg = load_ch & rx_word[`ASC_EN2_POS];

  asc_cfg_t cfg_in;                    // configuration field as shifted in
  asc_cfg_t cfg_eff;                   // field with temperature rule applied

  assign chan_nxt = load_ch  ? asc_chan_t'(rx_word[`ASC_CH_HI:`ASC_CH_LO]) : o_chan;
  assign cfg_in   = asc_cfg_t'(rx_word[`ASC_CFG_HI:`ASC_CFG_LO]);
  // temperature reading runs single rate: rate and gain bits dropped
  assign cfg_eff = '{temp_sensor_select: cfg_in.temp_sensor_select,
                     line_reject_upper:  cfg_in.line_reject_upper,
                     line_reject_lower:  cfg_in.line_reject_lower,
                     rate_double:        cfg_in.rate_double & ~cfg_in.temp_sensor_select,
                     gain_code_high:     cfg_in.gain_code_high & ~cfg_in.temp_sensor_select,
                     gain_code_mid:      cfg_in.gain_code_mid & ~cfg_in.temp_sensor_select,
                     gain_code_low:      cfg_in.gain_code_low & ~cfg_in.temp_sensor_select};
  assign cfg_nxt  = load_cfg ? cfg_eff : o_cfg;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ASC_CONV: begin
        if (conv_cnt_r == 32'(CONV_CYCLES - 1)) begin
          state_nxt = cs_s_r ? ASC_SLEEP : ASC_DATA;
        end
      end
      ASC_SLEEP: begin
        if (!cs_s_r) begin
          state_nxt = ASC_DATA;
        end
      end
      ASC_DATA: begin
        if (word_done) begin
          state_nxt = ASC_CONV;
        end else if (cs_rise) begin
          state_nxt = (rise_cnt != '0) ? ASC_CONV : ASC_SLEEP;
        end
      end
      default: state_nxt = ASC_CONV;
    endcase
  end

  // ****************************************************************
  // state, timer, result and configuration
  // ****************************************************************
  wire restart = (state_r == ASC_DATA) && (state_nxt == ASC_CONV);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_r    <= ASC_CONV;
      conv_cnt_r <= '0;
      o_chan     <= asc_chan_t'(`ASC_CH_RESET);
      o_cfg      <= asc_cfg_t'(`ASC_CFG_RESET);
      res_r      <= '0;
      arm_r      <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      conv_cnt_r <= (state_r == ASC_CONV) ? conv_cnt_r + 32'd1 : '0;
      if (state_r == ASC_CONV && state_nxt != ASC_CONV) begin
        res_r <= '{polarity_flag: pol, value: clamp_val};
      end
      if (restart && rise_cnt >= `ASC_CNT_W'(`ASC_IN_BITS)) begin
        o_chan <= chan_nxt;
        o_cfg  <= cfg_nxt;
      end
      if (cs_fall) begin
        arm_r <= ~arm_r;
      end
    end
  end

  // result only changes at conversion end, so the word stands while read
  always_ff @(posedge i_clk) begin
    word_r <= word_fmt;
  end

  // ****************************************************************
  // pin drive
  // ****************************************************************
  // status bit high while converting, low afterwards
  wire status_lvl = (state_r == ASC_CONV);
  assign o_sdo      = (state_r == ASC_DATA) ? tx_bit : status_lvl;
  assign o_sdo_oe_n = i_cs_n;
  assign o_converting = (state_r == ASC_CONV);
  assign o_sleeping   = (state_r == ASC_SLEEP);

endmodule // asc_serial_port

//--- include/asc_consts.svh
/*
 * constants for the converter serial port: word sizes, bit positions,
 * preamble codes, reset configuration and conversion timing.
 * assumes inclusion by the package and the design modules.
 */
`ifndef ASC_CONSTS_SVH
`define ASC_CONSTS_SVH

// ****************************************************************
// word sizes
// ****************************************************************
`define ASC_OUT_BITS      24
`define ASC_IN_BITS       16
`define ASC_RES_BITS      17
`define ASC_CNT_W         5

// ****************************************************************
// input word field positions (msb first, index 15 is first bit)
// ****************************************************************
`define ASC_PRE_HI        15
`define ASC_PRE_LO        13
`define ASC_CH_HI         12
`define ASC_CH_LO         8
`define ASC_EN2_POS       7
`define ASC_CFG_HI        6
`define ASC_CFG_LO        0
`define ASC_PRE_LOAD      3'h5

// ****************************************************************
// reset configuration
// ****************************************************************
`define ASC_CH_RESET      5'h00
`define ASC_CFG_RESET     7'h00

// ****************************************************************
// conversion timing
// ****************************************************************
`define ASC_CONV_US       1000
`define ASC_CLK_MHZ       25

`endif

//--- include/asc_pkg.sv
/*
 * types for the converter serial port.
 * assumes asc_consts.svh is on the include path.
 */
`include "asc_consts.svh"

package asc_pkg;

  // channel selection field
  typedef struct packed {
    logic       single_ended_select;
    logic       odd_sign;
    logic       channel_addr_high;
    logic       channel_addr_mid;
    logic       channel_addr_low;
  } asc_chan_t;

  // converter configuration field
  typedef struct packed {
    logic       temp_sensor_select;
    logic       line_reject_upper;
    logic       line_reject_lower;
    logic       rate_double;
    logic       gain_code_high;
    logic       gain_code_mid;
    logic       gain_code_low;
  } asc_cfg_t;

  // converter result as handed to the port
  typedef struct packed {
    logic                      polarity_flag;
    logic [`ASC_RES_BITS-1:0]  value;
  } asc_result_t;

endpackage

//--- logic/asc_sclk_side.sv
/*
 * link-clock half of the port: shift registers clocked by the serial
 * clock. assumes the serial clock idles low and the select is stable
 * around every serial clock edge the host makes; the system reset
 * clears this half asynchronously, since the serial clock is stopped then.
 */
`timescale 1ns/1ps
`include "asc_consts.svh"

module asc_sclk_side
  import asc_pkg::*;
#(
  parameter int OUT_BITS = `ASC_OUT_BITS,
  parameter int IN_BITS  = `ASC_IN_BITS
) (
  input  wire logic                 i_sclk,      // serial clock
  input  wire logic                 i_cs_n,      // chip select, async level
  input  wire logic                 i_clr,       // system reset, async clear
  input  wire logic                 i_frame_arm, // toggled at frame start
  input  wire logic [OUT_BITS-1:0]  i_word,      // word to send
  input  wire logic                 i_sdi,       // serial input
  output logic                      o_tx_bit,    // current outgoing bit
  output logic [`ASC_CNT_W-1:0]     o_rise_cnt,  // rising edges seen
  output logic                      o_done_tgl,  // toggles on full word
  output logic [IN_BITS-1:0]        o_rx_word    // captured input word
);

  // ****************************************************************
  // state on the serial clock
  // ****************************************************************
  logic                  arm_seen_r;   // last arm toggle taken
  logic                  fresh;        // first edge of new frame
  logic [OUT_BITS-1:0]   sh_r;         // outgoing shift register

  // arm toggles well before the first serial edge, so it is read as a level
  assign fresh = (i_frame_arm != arm_seen_r);

  // capture input on rising edges while selected, first word only
  always_ff @(posedge i_sclk or posedge i_clr) begin
    if (i_clr) begin
      arm_seen_r <= 1'b0;
      o_rx_word  <= '0;
      o_rise_cnt <= '0;
    end else if (!i_cs_n) begin
      arm_seen_r <= i_frame_arm;
      if (fresh || o_rise_cnt < `ASC_CNT_W'(IN_BITS)) begin
        o_rx_word <= {o_rx_word[IN_BITS-2:0], i_sdi};
      end
      o_rise_cnt <= fresh ? `ASC_CNT_W'(1)
                          : o_rise_cnt + `ASC_CNT_W'(1);
    end
  end

  // shift outgoing bits on falling edges; last fall drives the line high
  always_ff @(negedge i_sclk or posedge i_clr) begin
    if (i_clr) begin
      sh_r       <= '0;
      o_done_tgl <= 1'b0;
    end else if (!i_cs_n) begin
      if (o_rise_cnt == `ASC_CNT_W'(1)) begin
        sh_r <= {i_word[OUT_BITS-2:0], 1'b0};
      end else if (o_rise_cnt == `ASC_CNT_W'(OUT_BITS)) begin
        sh_r       <= '1;
        o_done_tgl <= ~o_done_tgl;
      end else begin
        sh_r <= {sh_r[OUT_BITS-2:0], 1'b0};
      end
    end
  end

  // bit on the wire: first bit until first rising edge
  assign o_tx_bit = (o_rise_cnt == '0 || fresh) ? i_word[OUT_BITS-1] : sh_r[OUT_BITS-1];

  // word sizes are wired into the frame counter
  if (OUT_BITS != `ASC_OUT_BITS || IN_BITS != `ASC_IN_BITS) begin : g_size_chk
    $error("asc_sclk_side: word sizes are fixed");
  end

endmodule // asc_sclk_side

//--- tb/asc_port_props.sv
/* checker for the serial port: select, status level and conversion timing.
   assumes it is bound to asc_serial_port and sees only its ports. */
`timescale 1ns/1ps
module asc_port_props
  import asc_pkg::*;
#(
  parameter int CONV_CYCLES = 50
) (
  input wire logic      i_clk,
  input wire logic      i_rst,
  input wire logic      i_cs_n,
  input wire logic      o_sdo,
  input wire logic      o_sdo_oe_n,
  input wire logic      o_converting,
  input wire logic      o_sleeping,
  input wire asc_chan_t o_chan,
  input wire asc_cfg_t  o_cfg
);
  // ****************
  // helper counter
  // ****************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  int run_r;  // cycles spent converting
  // counts the running conversion, cleared outside it
  always_ff @(posedge i_clk) begin
    run_r <= (i_rst || !o_converting) ? 0 : run_r + 1;
  end
  // ****************
  // properties
  // ****************
  sdo_release_a: assert property (
    i_cs_n [*3] |-> o_sdo_oe_n) else $error("line driven while deselected");
  sdo_drive_a: assert property (
    !i_cs_n [*3] |-> !o_sdo_oe_n) else $error("line released while selected");
  busy_status_a: assert property (
    o_converting && !i_cs_n && !o_sdo_oe_n |-> o_sdo) else $error("busy level low");
  done_status_a: assert property (
    o_sleeping && !o_sdo_oe_n |-> !o_sdo) else $error("done level high");
  conv_length_a: assert property (
    $fell(o_converting) |-> run_r >= CONV_CYCLES - 1 && run_r <= CONV_CYCLES + 1)
    else $error("conversion length wrong");
  sleep_entry_a: assert property (
    $rose(o_sleeping) |-> $past(o_converting)) else $error("sleep without conversion");
  sleep_hold_a: assert property (
    o_sleeping && i_cs_n ##1 i_cs_n |-> o_sleeping) else $error("left sleep unselected");
  sleep_exit_a: assert property (
    o_sleeping && !i_cs_n |-> ##[1:6] !o_sleeping) else $error("sleep not left");
  settings_update_a: assert property (
    !$stable(o_chan) || !$stable(o_cfg) |-> ##[0:3] o_converting)
    else $error("settings changed outside restart");
  cover property (o_sleeping ##1 !o_sleeping);
  cover property ($rose(o_converting));
  cover property (!$stable(o_chan));
endmodule // asc_port_props

//--- tb/asc_host_model.sv
/* host controller model: select, serial clock and serial input.
   assumes the bench calls frame only while the port sleeps. */
`timescale 1ns/1ps
module asc_host_model (
  output logic      o_sclk,  // serial clock, still outside frames except stray bursts
  output logic      o_cs_n,  // chip select
  output logic      o_sdi,   // serial data to the port
  input  wire logic i_sdo    // resolved serial out line
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi  = 1'b0;
  end
  // frame of nr rising edges, word msb first; short count aborts
  task automatic frame(input int nr, input logic [15:0] w,
                       output logic [23:0] q, output logic tail);
    q = 24'h00_0000;
    o_cs_n = 1'b0;
    #200;
    for (int k = 0; k < nr; k++) begin
      o_sdi = (k < 16) ? w[15-k] : ~o_sdi;
      #6 q[23-k] = i_sdo;
      o_sclk = 1'b1;
      #6 o_sclk = 1'b0;
    end
    #150 tail = i_sdo;
    o_cs_n = 1'b1;
    o_sdi = ~o_sdi;  // released line shows no stale value
  endtask
  // clock burst with select high, pattern looks like a load
  task automatic stray(input int n);
    for (int k = 0; k < n; k++) begin
      o_sdi = ~k[0];
      #6 o_sclk = 1'b1;
      #6 o_sclk = 1'b0;
    end
  endtask
endmodule // asc_host_model

//--- tb/adc_serial_config_port_tb_top.sv
/* bench for the serial port: host model on the link, result from the bench.
   assumes checker and host model are compiled first. */
`timescale 1ns/1ps
module adc_serial_config_port_tb_top;
  import asc_pkg::*;
  localparam int CONV = 50;  // shortened conversion
  logic        i_clk;         // system clock
  logic        i_rst;         // sync reset
  logic [16:0] i_result;      // core result
  logic        i_over;        // above full scale
  logic        i_under;       // below negative full scale
  wire         sclk;          // serial clock
  wire         cs_n;          // chip select
  wire         sdi;           // serial in
  wire         sdo_w;         // resolved serial out
  logic        o_sdo;
  logic        o_sdo_oe_n;
  logic        o_converting;
  logic        o_sleeping;
  asc_chan_t   o_chan;
  asc_cfg_t    o_cfg;
  logic [23:0] q;             // word read by host
  logic        tail;          // line after last fall
  int          bad_count;
  int          checks;
  assign sdo_w = o_sdo_oe_n ? 1'bz : o_sdo;
  asc_serial_port #(.CONV_CYCLES(CONV)) DUT (.i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk),
    .i_cs_n(cs_n), .i_sdi(sdi), .i_result(i_result), .i_over(i_over), .i_under(i_under),
    .o_sdo(o_sdo), .o_sdo_oe_n(o_sdo_oe_n), .o_converting(o_converting),
    .o_sleeping(o_sleeping), .o_chan(o_chan), .o_cfg(o_cfg));
  asc_host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo_w));
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] seen, input logic [23:0] want);
    checks++;
    if (seen !== want) begin
      bad_count++;
      $display("ERROR %0t: seen %h want %h", $time, seen, want);
    end
  endtask
  // bounded wait for sleep (1) or conversion (0)
  task automatic wait_lvl(input bit slp);
    int n;
    n = 0;
    while (((slp ? o_sleeping : o_converting) !== 1'b1) && n < 300) begin
      @(negedge i_clk);
      n++;
    end
    chk({23'h00_0000, n < 300}, 24'h00_0001);
    if (n >= 300) give_verdict();
  endtask
  // expected word: status, filler, polarity, result, four lows
  function automatic logic [23:0] exp_word(input logic [18:0] v);
    logic [17:0] sv;
    sv = v[18] ? 18'h3_0000 : v[17] ? 18'h0_ffff : {~v[16], v[16:0]};
    return {2'b00, sv, 4'h0};
  endfunction
  task automatic t_reset();
    chk({11'h000, o_converting, o_chan, o_cfg}, 24'h00_1000);
    wait_lvl(1'b1);
    $display("test reset done");
  endtask
  // each value but the last is read in the frame after its conversion
  task automatic t_words();
    logic [18:0] tv [5];
    logic [18:0] prev;
    tv = '{19'h0_1234, 19'h1_8001, 19'h4_0000, 19'h2_0000, 19'h0_0f0f};
    prev = 19'h0_0000;
    for (int i = 0; i < 5; i++) begin
      @(negedge i_clk);
      {i_over, i_under, i_result} = tv[i];
      host.frame(24, 16'h0000, q, tail);
      chk(q, exp_word(prev));
      chk({23'h00_0000, tail}, 24'h00_0001);
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      prev = tv[i];
    end
    $display("test words done");
  endtask
  task automatic t_config();
    host.frame(24, {3'h5, 5'h19, 1'b1, 7'h2b}, q, tail);
    wait_lvl(1'b1);
    chk({12'h000, o_chan, o_cfg}, 24'h00_0cab);
    host.frame(24, {3'h4, 13'h1fff}, q, tail);
    wait_lvl(1'b1);
    chk({12'h000, o_chan, o_cfg}, 24'h00_0cab);
    host.frame(24, {3'h5, 5'h01, 1'b0, 7'h7f}, q, tail);
    wait_lvl(1'b1);
    chk({12'h000, o_chan, o_cfg}, 24'h00_00ab);
    host.frame(24, {3'h5, 5'h01, 1'b1, 7'h5b}, q, tail);
    wait_lvl(1'b1);
    chk({12'h000, o_chan, o_cfg}, 24'h00_00d0);
    $display("test config done");
  endtask
  task automatic t_abort();
    host.frame(10, {3'h5, 5'h11, 1'b1, 7'h00}, q, tail);
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    chk({12'h000, o_chan, o_cfg}, 24'h00_00d0);
    $display("test abort done");
  endtask
  task automatic t_idle();
    host.stray(8);
    chk({22'h00_0000, o_sleeping, sdo_w}, {22'h00_0000, 2'b1z});
    host.frame(24, 16'h0000, q, tail);
    wait_lvl(1'b1);
    chk({12'h000, o_chan, o_cfg}, 24'h00_00d0);
    $display("test idle done");
  endtask
  initial begin
    i_rst = 1'b1;
    i_result = 17'h0_0000;
    i_over = 1'b0;
    i_under = 1'b0;
    bad_count = 0;
    checks = 0;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    i_rst = 1'b0;
    t_reset();
    t_words();
    t_config();
    t_abort();
    t_idle();
    give_verdict();
  end
endmodule // adc_serial_config_port_tb_top

bind asc_serial_port asc_port_props #(.CONV_CYCLES(CONV_CYCLES)) u_props (
  .i_clk(i_clk), .i_rst(i_rst), .i_cs_n(i_cs_n), .o_sdo(o_sdo), .o_sdo_oe_n(o_sdo_oe_n),
  .o_converting(o_converting), .o_sleeping(o_sleeping), .o_chan(o_chan), .o_cfg(o_cfg));
